// [core/la_trigger_capture.sv]
// trigger selection, capture windows and wishbone registers of the logic analyzer
//
// Decided for this implementation: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
module la_trigger_capture (
    input wire logic clk,
    input wire logic resetn,
    input wire la_pkg::wb_req_s wb_i,
    output la_pkg::wb_rsp_s wb_o,
    input wire logic [la_pkg::PROBE_W-1:0] probe,
    input wire logic external_trigger_input,
    output logic trig_out,
    output logic capturing
);
    import la_pkg::*;

    typedef struct packed {
        wb_rsp_s rsp;
        trig_mode_e mode;
        cap_mode_e cap;
        tout_e tout;
        logic comb_and;
        logic [31:0] cval;
        logic [31:0] cmask;
        logic [31:0] qval;
        logic [31:0] qmask;
        logic [7:0] seq_sel;
        logic [1:0] seq_last;
        logic [1:0] seq_step;
        logic [AW-1:0] nwin_m1;
        logic [AW-1:0] depth_m1;
        logic [AW-1:0] tpos;
        logic [AW-1:0] win;
        logic [AW-1:0] base;
        logic [AW-1:0] widx;
        logic [AW-1:0] filled;
        logic [AW-1:0] post_left;
        logic [AW-1:0] tidx;
        logic [AW-1:0] raddr;
        phase_e phase;
        logic done;
        logic triggered;
        logic ext_prev;
        logic trig_out;
        logic capturing;
    } st_s;

    st_s s;
    st_s next_s;
    logic [PROBE_W-1:0] mem [MEM_DEPTH];
    logic [NPROBE-1:0] match;
    logic [NPROBE-1:0] en;
    logic basic_hit;
    logic qual_hit;
    logic seq_adv;
    logic seq_hit;
    logic ext_edge;
    logic trig_hit;
    logic fire;
    logic store;
    logic mem_we;
    logic [AW-1:0] mem_addr;
    logic req;
    logic arm_wr;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    // ==========================================
    // per-probe comparators
    for (genvar i = 0; i < NPROBE; i++) begin : g_cmp
        assign match[i] = ((probe[8*i +: 8] ^ s.cval[8*i +: 8]) & s.cmask[8*i +: 8]) == 8'h00;
        assign en[i] = |s.cmask[8*i +: 8];
    end

    // ==========================================
    // trigger sources
    always_comb begin
        basic_hit = s.comb_and ? ((&(match | ~en)) && (|en)) : (|(match & en));
        qual_hit = ((probe ^ s.qval) & s.qmask) == 32'h0000_0000;
        seq_adv = match[s.seq_sel[2*s.seq_step +: 2]];
        seq_hit = seq_adv && (s.seq_step == s.seq_last);
        ext_edge = external_trigger_input && !s.ext_prev;
        case (s.mode)
            compare_trigger_mode: trig_hit = basic_hit;
            sequencer_trigger_mode: trig_hit = seq_hit;
            external_edge_trigger_mode: trig_hit = ext_edge;
            compare_or_external_trigger_mode: begin
                trig_hit = external_trigger_input || basic_hit;
            end
            sequencer_or_external_trigger_mode: begin
                trig_hit = external_trigger_input || seq_hit;
            end
            default: trig_hit = 1'b0;
        endcase
        fire = (s.phase == phase_pre) && (s.filled == s.tpos) && trig_hit;
        store = (s.cap == unfiltered_capture) || qual_hit;
        mem_we = (s.phase != phase_idle) && store;
        mem_addr = s.base + s.widx;
        req = wb_i.cyc && wb_i.stb && !s.rsp.ack;
        arm_wr = req && wb_i.we && (wb_i.adr == CTRL_OFF) && wb_i.sel[0] && wb_i.dat[CTRL_ARM];
    end

    // ==========================================
    // capture sequencing and register bus
    always_comb begin
        next_s = s;
        next_s.ext_prev = external_trigger_input;
        if (mem_we) begin
            next_s.widx = (s.widx == s.depth_m1) ? '0 : s.widx + 1'b1;
        end
        case (s.phase)
            phase_idle: begin
            end
            phase_pre: begin
                if (mem_we && (s.filled != s.tpos)) begin
                    next_s.filled = s.filled + 1'b1;
                end
                if (fire) begin
                    next_s.triggered = 1'b1;
                    next_s.tidx = s.widx;
                    next_s.post_left = s.depth_m1 - s.tpos;
                    next_s.phase = phase_post;
                end else if (seq_adv && (s.seq_step != s.seq_last)) begin
                    next_s.seq_step = s.seq_step + 1'b1;
                end
            end
            phase_post: begin
                if (mem_we) begin
                    next_s.post_left = s.post_left - 1'b1;
                end
            end
            default: next_s.phase = phase_idle;
        endcase
        // window end
        if (next_s.phase == phase_post && next_s.post_left == '0) begin
            if (s.win == s.nwin_m1) begin
                next_s.phase = phase_idle;
                next_s.done = 1'b1;
            end else begin
                next_s.win = s.win + 1'b1;
                next_s.base = s.base + s.depth_m1 + 1'b1;
                next_s.widx = '0;
                next_s.filled = '0;
                next_s.seq_step = '0;
                next_s.phase = phase_pre;
            end
        end
        // bus
        next_s.rsp.ack = req;
        next_s.rsp.dat = 32'h0000_0000;
        if (req && wb_i.we) begin
            case (wb_i.adr)
                CTRL_OFF: begin
                    if (wb_i.sel[0]) begin
                        next_s.mode = trig_mode_e'(wb_i.dat[CTRL_MODE +: 3]);
                        next_s.cap = cap_mode_e'(wb_i.dat[CTRL_CAP]);
                        next_s.tout = tout_e'(wb_i.dat[CTRL_TOUT +: 2]);
                        if (wb_i.dat[CTRL_STOP]) begin
                            next_s.phase = phase_idle;
                        end
                        if (wb_i.dat[CTRL_ARM]) begin
                            next_s.phase = phase_pre;
                            next_s.win = '0;
                            next_s.base = '0;
                            next_s.widx = '0;
                            next_s.filled = '0;
                            next_s.seq_step = '0;
                            next_s.done = 1'b0;
                            next_s.triggered = 1'b0;
                        end
                    end
                    if (wb_i.sel[1]) begin
                        next_s.comb_and = wb_i.dat[CTRL_AND];
                    end
                end
                NWIN_OFF: begin
                    next_s.nwin_m1 = AW'(merge(32'(s.nwin_m1), wb_i.dat, wb_i.sel));
                end
                DEPTH_OFF: begin
                    next_s.depth_m1 = AW'(merge(32'(s.depth_m1), wb_i.dat, wb_i.sel));
                end
                TPOS_OFF: next_s.tpos = AW'(merge(32'(s.tpos), wb_i.dat, wb_i.sel));
                CVAL_OFF: next_s.cval = merge(s.cval, wb_i.dat, wb_i.sel);
                CMASK_OFF: next_s.cmask = merge(s.cmask, wb_i.dat, wb_i.sel);
                QVAL_OFF: next_s.qval = merge(s.qval, wb_i.dat, wb_i.sel);
                QMASK_OFF: next_s.qmask = merge(s.qmask, wb_i.dat, wb_i.sel);
                SEQ_OFF: begin
                    if (wb_i.sel[0]) begin
                        next_s.seq_sel = wb_i.dat[7:0];
                    end
                    if (wb_i.sel[1]) begin
                        next_s.seq_last = wb_i.dat[SEQ_LAST +: 2];
                    end
                end
                RADDR_OFF: next_s.raddr = AW'(merge(32'(s.raddr), wb_i.dat, wb_i.sel));
                default: begin
                end
            endcase
        end else if (req) begin
            case (wb_i.adr)
                CTRL_OFF: next_s.rsp.dat = 32'({s.comb_and, s.tout, s.cap, s.mode, 2'b00});
                NWIN_OFF: next_s.rsp.dat = 32'(s.nwin_m1);
                DEPTH_OFF: next_s.rsp.dat = 32'(s.depth_m1);
                TPOS_OFF: next_s.rsp.dat = 32'(s.tpos);
                CVAL_OFF: next_s.rsp.dat = s.cval;
                CMASK_OFF: next_s.rsp.dat = s.cmask;
                QVAL_OFF: next_s.rsp.dat = s.qval;
                QMASK_OFF: next_s.rsp.dat = s.qmask;
                SEQ_OFF: next_s.rsp.dat = 32'({s.seq_last, s.seq_sel});
                STAT_OFF: next_s.rsp.dat = 32'({s.done, s.triggered, s.phase});
                POS_OFF: next_s.rsp.dat = (32'(s.tidx) << POS_TIDX) | 32'(s.win);
                RADDR_OFF: next_s.rsp.dat = 32'(s.raddr);
                RDATA_OFF: begin
                    next_s.rsp.dat = mem[s.raddr];
                    next_s.raddr = s.raddr + 1'b1;
                end
                default: next_s.rsp.dat = 32'h0000_0000;
            endcase
        end
        // trigger output
        case (s.tout)
            tout_pulse: next_s.trig_out = fire;
            tout_level: next_s.trig_out = next_s.triggered;
            tout_pulse_low: next_s.trig_out = !fire;
            default: next_s.trig_out = 1'b0;
        endcase
        next_s.capturing = next_s.phase != phase_idle;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            s <= '0;
            s.nwin_m1 <= RST_NWIN_M1;
            s.depth_m1 <= RST_DEPTH_M1;
            s.tpos <= RST_TPOS;
        end else begin
            s <= next_s;
        end
    end

    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem[mem_addr] <= probe;
        end
    end

    assign wb_o = s.rsp;
    assign trig_out = s.trig_out;
    assign capturing = s.capturing;

    // ==========================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence last_store_s;
        s.phase == phase_post && mem_we && s.post_left == 10'h001 && s.win == s.nwin_m1 && !arm_wr;
    endsequence
    sequence idle_after_s;
        s.done && s.phase == phase_idle && !capturing ##1 !mem_we;
    endsequence

    chk_basic_fire: assert property (s.mode == compare_trigger_mode && fire
        |-> basic_hit)
        else $error("compare trigger fired without hit");
    chk_seq_fire: assert property (s.mode == sequencer_trigger_mode && fire |-> seq_hit)
        else $error("sequencer trigger fired early");
    chk_ext_edge: assert property (s.mode == external_edge_trigger_mode && fire
        |-> external_trigger_input && !$past(external_trigger_input))
        else $error("external trigger fired without rising edge");
    chk_or_fire: assert property (s.mode == compare_or_external_trigger_mode
        && s.phase == phase_pre && s.filled == s.tpos && external_trigger_input && !arm_wr
        |=> s.triggered)
        else $error("external input ignored in combined mode");
    chk_filter_store: assert property (s.cap == filtered_capture && mem_we |-> qual_hit)
        else $error("unqualified sample stored");
    chk_unfilt_store: assert property (s.cap == unfiltered_capture
        && s.phase != phase_idle |-> mem_we)
        else $error("sample dropped in unfiltered capture");
    chk_window_range: assert property (s.phase != phase_idle && !arm_wr
        ##1 s.phase != phase_idle |-> s.win <= s.nwin_m1)
        else $error("window count beyond setting");
    chk_depth_wrap: assert property (mem_we && s.widx == s.depth_m1
        && s.phase == phase_pre && !fire && !arm_wr |=> s.widx == 10'h000)
        else $error("window index did not wrap");
    chk_pre_count: assert property (fire |-> s.filled == s.tpos)
        else $error("trigger taken before pre-trigger filled");
    chk_tout_pulse: assert property (s.tout == tout_pulse |=> trig_out == $past(fire))
        else $error("trigger pulse missing");
    chk_tout_off: assert property (s.tout == tout_off |=> !trig_out)
        else $error("trigger output active while off");
    chk_last_window: assert property (last_store_s |=> idle_after_s)
        else $error("capture did not stop after last window");
    chk_stat_idle: assert property (s.phase == phase_idle && req && !wb_i.we
        && wb_i.adr == STAT_OFF |=> wb_o.ack && wb_o.dat[1:0] == 2'b00)
        else $error("status not idle");
endmodule

// [pkg/la_pkg.sv]
// constants and types for the logic analyzer trigger and capture block
package la_pkg;
    // ==========================================
    // sizes
    localparam int PROBE_W = 32;
    localparam int NPROBE = 4;
    localparam int AW = 10;
    localparam int MEM_DEPTH = 1024;
    // ==========================================
    // register byte offsets
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] NWIN_OFF = 8'h04;
    localparam logic [7:0] DEPTH_OFF = 8'h08;
    localparam logic [7:0] TPOS_OFF = 8'h0c;
    localparam logic [7:0] CVAL_OFF = 8'h10;
    localparam logic [7:0] CMASK_OFF = 8'h14;
    localparam logic [7:0] QVAL_OFF = 8'h18;
    localparam logic [7:0] QMASK_OFF = 8'h1c;
    localparam logic [7:0] SEQ_OFF = 8'h20;
    localparam logic [7:0] STAT_OFF = 8'h24;
    localparam logic [7:0] POS_OFF = 8'h28;
    localparam logic [7:0] RADDR_OFF = 8'h2c;
    localparam logic [7:0] RDATA_OFF = 8'h30;
    // ==========================================
    // field positions
    localparam int CTRL_ARM = 0;
    localparam int CTRL_STOP = 1;
    localparam int CTRL_MODE = 2;
    localparam int CTRL_CAP = 5;
    localparam int CTRL_TOUT = 6;
    localparam int CTRL_AND = 8;
    localparam int SEQ_LAST = 8;
    localparam int STAT_TRIG = 2;
    localparam int STAT_DONE = 3;
    localparam int POS_TIDX = 16;
    // ==========================================
    // reset values
    localparam logic [AW-1:0] RST_NWIN_M1 = 10'h000;
    localparam logic [AW-1:0] RST_DEPTH_M1 = 10'h3ff;
    localparam logic [AW-1:0] RST_TPOS = 10'h000;
    // ==========================================
    // types
    typedef enum logic [2:0] {
        compare_trigger_mode = 3'b000,
        sequencer_trigger_mode = 3'b001,
        external_edge_trigger_mode = 3'b010,
        compare_or_external_trigger_mode = 3'b011,
        sequencer_or_external_trigger_mode = 3'b100
    } trig_mode_e;
    typedef enum logic {unfiltered_capture = 1'b0, filtered_capture = 1'b1} cap_mode_e;
    typedef enum logic [1:0] {
        tout_off = 2'b00, tout_pulse = 2'b01, tout_level = 2'b10, tout_pulse_low = 2'b11
    } tout_e;
    typedef enum logic [1:0] {
        phase_idle = 2'b00, phase_pre = 2'b01, phase_post = 2'b10
    } phase_e;
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_s;
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } wb_rsp_s;
endpackage

// [tb/probe_source.sv]
// partner model: probed user design counter and external trigger source
`timescale 1ns/1ps
module probe_source (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ext_req,
    output logic [31:0] probe,
    output logic ext
);
    logic [7:0] cnt;
    // ==========================================
    // free running count, byte i shows count plus i
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cnt <= 8'h00;
            ext <= 1'b0;
        end else begin
            cnt <= cnt + 8'h01;
            ext <= ext_req;
        end
    end
    assign probe = {cnt + 8'h03, cnt + 8'h02, cnt + 8'h01, cnt};
endmodule

// [tb/logic_analyzer_trigger_capture_tb.sv]
// self-checking bench for the trigger and capture block
`timescale 1ns/1ps
module logic_analyzer_trigger_capture_tb;
    import la_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic ext_req = 1'b0;
    wb_req_s wb_i = '0;
    wb_rsp_s wb_o;
    logic [31:0] probe;
    logic ext;
    logic trig_out;
    logic capturing;
    int bad_count = 0;
    int check_count = 0;
    int hi_cnt = 0;
    int lo_cnt = 0;
    int k;
    logic [31:0] q;
    logic [7:0] ra [6] = '{CTRL_OFF, NWIN_OFF, DEPTH_OFF, TPOS_OFF, STAT_OFF, 8'h40};
    logic [31:0] rv [6] = '{32'h0, 32'h0, 32'h3ff, 32'h0, 32'h0, 32'h0};
    // ==========================================
    // clock, partner and design
    always #5 clk = ~clk;
    always @(posedge clk) hi_cnt <= hi_cnt + ((trig_out === 1'b1) ? 1 : 0);
    always @(posedge clk) lo_cnt <= lo_cnt + ((trig_out === 1'b0) ? 1 : 0);
    probe_source src (.clk(clk), .resetn(resetn), .ext_req(ext_req), .probe(probe), .ext(ext));
    la_trigger_capture dut (.clk(clk), .resetn(resetn), .wb_i(wb_i), .wb_o(wb_o),
        .probe(probe), .external_trigger_input(ext), .trig_out(trig_out),
        .capturing(capturing));
    // ==========================================
    // tasks and expectations
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
        @(posedge clk);
        while (wb_o.ack !== 1'b1) begin
            n++;
            if (n > 50) begin
                bad_count++;
                end_sim();
            end
            @(posedge clk);
        end
        q = wb_o.dat;
        wb_i <= '0;
        @(posedge clk);
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        do begin
            wb(1'b0, STAT_OFF, 32'h0);
            n++;
        end while (q[STAT_DONE] !== 1'b1 && n < 400);
        chk("status done", q, 32'hc);
    endtask
    function automatic logic [31:0] cw(input trig_mode_e m, input int tout, input int filt,
        input int andc);
        return (32'(m) << CTRL_MODE) | (32'(tout) << CTRL_TOUT) | (32'(filt) << CTRL_CAP)
            | (32'(andc) << CTRL_AND);
    endfunction
    function automatic logic [7:0] sample_at(input int kx, input int st, input int t,
        input int j);
        if (j == 0) return 8'(kx);
        if (j <= 3 - t) return 8'(kx + j * st);
        return 8'(kx - (4 - j) * st);
    endfunction
    task automatic cap(input logic [31:0] ctrl, input logic [31:0] cv, input logic [31:0] sq,
        input logic [31:0] qm, input int kx, input int st);
        int t;
        int h;
        int ti;
        logic [31:0] w [4];
        t = $urandom_range(0, 2);
        wb(1'b1, NWIN_OFF, 32'h0);
        wb(1'b1, DEPTH_OFF, 32'h3);
        wb(1'b1, TPOS_OFF, 32'(t));
        wb(1'b1, CVAL_OFF, cv);
        wb(1'b1, CMASK_OFF, 32'hffff);
        wb(1'b1, SEQ_OFF, sq);
        wb(1'b1, QVAL_OFF, 32'h0);
        wb(1'b1, QMASK_OFF, qm);
        h = hi_cnt;
        wb(1'b1, CTRL_OFF, ctrl | 32'h1);
        @(posedge clk);
        chk("capturing", {31'h0, capturing}, 32'h1);
        wait_done();
        case (ctrl[7:6])
            2'b00: chk("out quiet", 32'(hi_cnt - h), 32'h0);
            2'b01: chk("out pulse", 32'(hi_cnt - h), 32'h1);
            2'b10: chk("out level", {31'h0, trig_out}, 32'h1);
            default: ;
        endcase
        wb(1'b0, POS_OFF, 32'h0);
        chk("trigger window", {24'h0, q[25:18]}, 32'h0);
        chk("window", 32'(q[9:0]), 32'h0);
        ti = int'(q[17:16]);
        wb(1'b1, RADDR_OFF, 32'h0);
        for (int i = 0; i < 4; i++) begin
            wb(1'b0, RDATA_OFF, 32'h0);
            w[i] = q;
        end
        for (int j = 0; j < 4; j++) begin
            chk("sample", 32'(w[(ti + j) % 4][7:0]), 32'(sample_at(kx, st, t, j)));
        end
    endtask
    // ==========================================
    // watchdog
    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        end_sim();
    end
    // ==========================================
    // scenarios
    initial begin
        void'($urandom(32'h4342f70b));
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 6; i++) begin
            wb(1'b0, ra[i], 32'h0);
            chk("reset value", q, rv[i]);
        end
        k = $urandom_range(0, 255);
        cap(cw(compare_trigger_mode, 0, 0, 1), {16'h0, 8'(k + 1), 8'(k)}, 0, 0, k, 1);
        k = $urandom_range(0, 255);
        cap(cw(compare_trigger_mode, 1, 0, 0), {16'h0, 8'(k + 1), 8'(k)}, 0, 0, k, 1);
        k = 2 * $urandom_range(0, 127);
        cap(cw(compare_trigger_mode, 0, 1, 1), {16'h0, 8'(k + 1), 8'(k)}, 0, 1, k, 2);
        k = $urandom_range(0, 255);
        cap(cw(sequencer_trigger_mode, 2, 0, 1), {16'h0, 8'(k + 2), 8'(k)}, 32'h104, 0, k + 1,
            1);
        ext_req <= 1'b1;
        wb(1'b1, TPOS_OFF, 32'h0);
        wb(1'b1, CTRL_OFF, cw(external_edge_trigger_mode, 0, 0, 0) | 32'h1);
        repeat (30) @(posedge clk);
        ext_req <= 1'b0;
        repeat (3) @(posedge clk);
        wb(1'b0, STAT_OFF, 32'h0);
        chk("no edge yet", q, 32'h1);
        ext_req <= 1'b1;
        wait_done();
        for (int m = 3; m < 5; m++) begin
            wb(1'b1, CTRL_OFF, cw(trig_mode_e'(m), 0, 0, 1) | 32'h1);
            wait_done();
        end
        ext_req <= 1'b0;
        wb(1'b1, CVAL_OFF, 32'h0500);
        wb(1'b1, CTRL_OFF, cw(compare_trigger_mode, 0, 0, 1) | 32'h1);
        repeat (300) @(posedge clk);
        wb(1'b0, STAT_OFF, 32'h0);
        chk("armed waiting", q, 32'h1);
        wb(1'b1, CTRL_OFF, 32'h2);
        wb(1'b0, STAT_OFF, 32'h0);
        chk("stopped idle", q, 32'h0);
        wb(1'b1, NWIN_OFF, 32'h2);
        wb(1'b1, CVAL_OFF, 32'h0);
        wb(1'b1, CMASK_OFF, 32'hf);
        wb(1'b1, CTRL_OFF, cw(compare_trigger_mode, 3, 0, 1) | 32'h1);
        k = lo_cnt;
        wait_done();
        chk("out pulse low", 32'(lo_cnt - k), 32'h3);
        wb(1'b0, POS_OFF, 32'h0);
        chk("last window", 32'(q[9:0]), 32'h2);
        repeat (20) @(posedge clk);
        chk("stays idle", {31'h0, capturing}, 32'h0);
        end_sim();
    end
endmodule
